// ---- logic/alsg_pkg.sv ----
/*
 auxiliary local-store gating package: register indices, control word field
 codes, byte forcing values and the packed carriers shared by the block.
 assumes a 7-bit auxiliary address space and 32-bit data words.
*/
package alsg_pkg;
   // ---------------------------------------------------------------
   // register indices (byte address equals index in this space)
   // ---------------------------------------------------------------
   localparam logic [6:0] ADDR_V_REG        = 7'h51;
   localparam logic [6:0] ADDR_W_REG        = 7'h52;
   localparam logic [6:0] ADDR_STATUS_DISP  = 7'h56;
   localparam logic [6:0] ADDR_SHARE_PTR_2  = 7'h60;
   localparam logic [6:0] ADDR_SHARE_BKP_2  = 7'h61;
   localparam logic [6:0] ADDR_SHARE_PTR_3  = 7'h64;
   localparam logic [6:0] ADDR_SHARE_BKP_3  = 7'h65;
   localparam logic [6:0] ADDR_SHARE_PTR_1  = 7'h68;
   localparam logic [6:0] ADDR_SHARE_BKP_1  = 7'h69;
   localparam logic [6:0] ADDR_SHARE_PTR_4  = 7'h6c;
   localparam logic [6:0] ADDR_SHARE_BKP_4  = 7'h6d;
   localparam logic [6:0] ADDR_SEGMENT_GATE = 7'h78;
   localparam logic [6:0] ADDR_PAGE_GATE    = 7'h79;
   localparam logic [6:0] ADDR_SCRATCH_WORK = 7'h7a;
   localparam logic [6:0] ADDR_TRANS_CTRL   = 7'h7b;
   localparam logic [6:0] ADDR_TLB_TARGET   = 7'h7c;

   // ---------------------------------------------------------------
   // control word field codes
   // ---------------------------------------------------------------
   localparam logic [4:0] C0_WORD_MOVE   = 5'h06;  // 00110
   localparam logic [3:0] C2_W_B_SOURCE  = 4'h2;   // 0010
   localparam logic [4:0] C0_ARITH       = 5'h18;  // 11000
   localparam logic [3:0] C1_V_A_SOURCE  = 4'h1;   // 0001
   localparam logic [3:0] P_LOW_PAGE_TWO = 4'h2;
   localparam logic [3:0] P_LOW_PAGE_AUX = 4'h7;   // page of the upper aux block

   // ---------------------------------------------------------------
   // byte forcing and reset values
   // ---------------------------------------------------------------
   localparam logic [7:0]  BYTE_ALL_ONES = 8'hff;
   localparam logic [7:0]  BYTE_ZERO     = 8'h00;
   localparam logic [31:0] WORD_RESET    = 32'h0000_0000;
   localparam logic [31:0] BKP_KEEP_MASK = 32'h00ff_ff00;  // bytes 1 and 2 only
   localparam logic [31:0] STS_HI_MASK   = 32'h0000_ffff;  // bytes 0,1 forced zero
   localparam int          STS_B3_CTRL_ADDR_OUT_OF_RANGE_FLAG = 1;   // bit 6 of byte 3 (msb-0)
   localparam int          STS_B3_LOW    = 0;   // bit 7 of byte 3 (msb-0)

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [4:0] c0;      // operation class field
      logic [3:0] c1;      // a-source field
      logic [3:0] c2;      // b-source field
      logic       a_dest;  // a-source is also destination
   } alsg_cword_t;

   typedef struct packed {
      logic       a_gate;  // a-side aux gate
      logic       b_gate;  // b-side aux gate
      logic [6:0] addr;    // selected aux register
   } alsg_sel_t;

   typedef struct packed {
      logic [3:0] check_cause;  // parity/adder check sources
      logic       x_zero;
      logic       b_zero;
      logic       out_of_range; // control address outside fetch range
      logic       branch_point;
      logic       alt_start;    // deviate from opcode-derived start
      logic [7:0] byte2;        // byte 2 display bits
   } alsg_fetch_sts_t;
endpackage : alsg_pkg

// ---- logic/alsg_gating.sv ----
/*
 auxiliary local-store gating: intercepts control word source fields,
 selects an auxiliary register onto the a or b path, blocks ordinary
 local-store sense latches and bit gates, latches the destination address,
 and holds the auxiliary registers plus the fetch status display.
 assumes one clock per control-word cycle and that source fields arrive
 early, while the word is read from control storage, from logic on the
 same clock.
*/
`timescale 1ns/10ps
module alsg_gating (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   // control word intercepted from control storage
   input  wire logic                     cw_valid,
   input  wire alsg_pkg::alsg_cword_t    cw_fields,
   input  wire logic [3:0]               p_low,
   input  wire logic [6:0]               a_src_addr,
   input  wire logic                     a_src_is_aux,
   input  wire logic [6:0]               b_src_addr,
   input  wire logic                     b_src_is_aux,
   // destination write from the d register
   input  wire logic                     dest_wr,
   input  wire logic [31:0]              dest_data,
   // hardware-loaded values
   input  wire logic [6:0]               hw_special_addr,
   input  wire logic [31:0]              hw_special_data,
   input  wire alsg_pkg::alsg_fetch_sts_t fetch_sts,
   // console display
   input  wire logic [6:0]               console_addr,
   // gating outputs to the data flow
   output logic                          a_side_aux_gate,
   output logic                          b_side_aux_gate,
   output logic                          a_sense_block,
   output logic                          b_sense_block,
   output logic                          ls_bit_gate_block,
   output logic                          dest_latch_valid,
   output logic [6:0]                    dest_latch_addr,
   output logic [31:0]                   a_asm_data,
   output logic [31:0]                   b_asm_data,
   output logic [31:0]                   b_ls_bus,
   output logic [31:0]                   console_data
);
   // ---------------------------------------------------------------
   // read forcing helper
   // ---------------------------------------------------------------
   // one decoder serves both assemblers and the console path
   function automatic logic [31:0] aux_read(input logic [6:0] addr,
                                            input logic [31:0] ptr [4],
                                            input logic [31:0] bkp [4],
                                            input logic [31:0] seg,
                                            input logic [31:0] pag,
                                            input logic [31:0] wrk,
                                            input logic [31:0] trn,
                                            input logic [31:0] tlb,
                                            input logic [31:0] vr,
                                            input logic [31:0] wr);
      logic [31:0] r;
      r = alsg_pkg::WORD_RESET;
      unique case (addr)
         alsg_pkg::ADDR_SHARE_PTR_1:  r = ptr[0];
         alsg_pkg::ADDR_SHARE_PTR_2:  r = ptr[1];
         alsg_pkg::ADDR_SHARE_PTR_3:  r = ptr[2];
         alsg_pkg::ADDR_SHARE_PTR_4:  r = ptr[3];
         alsg_pkg::ADDR_SHARE_BKP_1:  r = bkp[0] & alsg_pkg::BKP_KEEP_MASK;
         alsg_pkg::ADDR_SHARE_BKP_2:  r = bkp[1] & alsg_pkg::BKP_KEEP_MASK;
         alsg_pkg::ADDR_SHARE_BKP_3:  r = bkp[2] & alsg_pkg::BKP_KEEP_MASK;
         alsg_pkg::ADDR_SHARE_BKP_4:  r = bkp[3] & alsg_pkg::BKP_KEEP_MASK;
         alsg_pkg::ADDR_SEGMENT_GATE:
            r = {alsg_pkg::BYTE_ALL_ONES, alsg_pkg::BYTE_ZERO, seg[15:0]};
         alsg_pkg::ADDR_PAGE_GATE:
            r = {alsg_pkg::BYTE_ALL_ONES, alsg_pkg::BYTE_ZERO, pag[15:0]};
         alsg_pkg::ADDR_SCRATCH_WORK:
            r = {alsg_pkg::BYTE_ALL_ONES, wrk[23:0]};
         alsg_pkg::ADDR_TRANS_CTRL:   r = trn;
         alsg_pkg::ADDR_TLB_TARGET:   r = tlb;
         alsg_pkg::ADDR_V_REG:        r = vr;
         alsg_pkg::ADDR_W_REG:        r = wr;
         default:                     r = alsg_pkg::WORD_RESET;
      endcase
      return r;
   endfunction : aux_read

   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [31:0] share_ptr_q [4];
   logic [31:0] share_bkp_q [4];
   logic [31:0] segment_gate_reg_q;
   logic [31:0] page_gate_reg_q;
   logic [31:0] scratch_work_reg_q;
   logic [31:0] translation_control_reg_q;
   logic [31:0] tlb_target_reg_q;
   logic [31:0] v_reg_q;
   logic [31:0] w_reg_q;

   // ---------------------------------------------------------------
   // source field intercept and address assembly
   // ---------------------------------------------------------------
   // w and v example decodes need no page bit, so they fire on any page
   wire logic w_bsrc_hit = (cw_fields.c0 == alsg_pkg::C0_WORD_MOVE)
                           && (cw_fields.c2 == alsg_pkg::C2_W_B_SOURCE);
   wire logic v_asrc_hit = (cw_fields.c0 == alsg_pkg::C0_ARITH)
                           && (cw_fields.c1 == alsg_pkg::C1_V_A_SOURCE);
   wire logic a_sel = cw_valid && (a_src_is_aux || v_asrc_hit);
   wire logic b_sel = cw_valid && (b_src_is_aux || w_bsrc_hit);
   wire logic [6:0] a_addr = v_asrc_hit ? alsg_pkg::ADDR_V_REG : a_src_addr;
   wire logic [6:0] b_addr_raw = w_bsrc_hit ? alsg_pkg::ADDR_W_REG : b_src_addr;
   // two aux sources in one word: the b side follows the a selection
   wire logic [6:0] sel_addr = a_sel ? a_addr : b_addr_raw;
   // console display address may never be reached by microcode
   wire logic sel_legal = (sel_addr != alsg_pkg::ADDR_STATUS_DISP);
   wire logic dest_hit = cw_valid && a_sel && cw_fields.a_dest;

   // captured as the word is read so gates are ready at cycle start
   alsg_pkg::alsg_sel_t sel_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         sel_q <= '0;
      end else begin
         sel_q <= '{a_gate: a_sel && sel_legal, b_gate: b_sel && sel_legal,
                    addr: sel_addr};
      end
   end

   // ---------------------------------------------------------------
   // assembler data: one register drives both assemblers
   // ---------------------------------------------------------------
   wire logic [31:0] sel_data = aux_read(sel_q.addr, share_ptr_q, share_bkp_q,
                                         segment_gate_reg_q, page_gate_reg_q,
                                         scratch_work_reg_q, translation_control_reg_q,
                                         tlb_target_reg_q, v_reg_q, w_reg_q);
   wire logic [31:0] sts_word = {alsg_pkg::BYTE_ZERO, alsg_pkg::BYTE_ZERO,
                                 fetch_sts.byte2,
                                 fetch_sts.check_cause,
                                 fetch_sts.x_zero, fetch_sts.b_zero,
                                 fetch_sts.out_of_range || fetch_sts.branch_point,
                                 fetch_sts.alt_start};
   wire logic [31:0] con_data = (console_addr == alsg_pkg::ADDR_STATUS_DISP)
                                ? (sts_word & alsg_pkg::STS_HI_MASK)
                                : aux_read(console_addr, share_ptr_q, share_bkp_q,
                                           segment_gate_reg_q, page_gate_reg_q,
                                           scratch_work_reg_q, translation_control_reg_q,
                                           tlb_target_reg_q, v_reg_q, w_reg_q);

   // ---------------------------------------------------------------
   // gating outputs, all registered
   // ---------------------------------------------------------------
   // gates and blocks move together so a latch never loads over an aux value
   always_ff @(posedge core_clk) begin
      if (rst) begin
         a_side_aux_gate   <= 1'b0;
         b_side_aux_gate   <= 1'b0;
         a_sense_block     <= 1'b0;
         b_sense_block     <= 1'b0;
         a_asm_data        <= alsg_pkg::WORD_RESET;
         b_asm_data        <= alsg_pkg::WORD_RESET;
         b_ls_bus          <= alsg_pkg::WORD_RESET;
         console_data      <= alsg_pkg::WORD_RESET;
      end else begin
         a_side_aux_gate   <= sel_q.a_gate;
         b_side_aux_gate   <= sel_q.b_gate;
         a_sense_block     <= sel_q.a_gate;
         b_sense_block     <= sel_q.b_gate;
         a_asm_data        <= sel_data;
         b_asm_data        <= sel_data;
         b_ls_bus          <= sel_q.b_gate ? sel_data : alsg_pkg::WORD_RESET;
         console_data      <= con_data;
      end
   end

   // ---------------------------------------------------------------
   // destination latches
   // ---------------------------------------------------------------
   // held one control-word cycle so the write lands in the next one
   always_ff @(posedge core_clk) begin
      if (rst) begin
         dest_latch_valid <= 1'b0;
         dest_latch_addr  <= '0;
      end else begin
         dest_latch_valid <= dest_hit && sel_legal;
         dest_latch_addr  <= a_addr;
      end
   end

   // aux destination write blocks both ordinary bit gates
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ls_bit_gate_block <= 1'b0;
      end else begin
         ls_bit_gate_block <= dest_latch_valid && dest_wr;
      end
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   // hardware load of v/w takes effect when no microcode write collides
   wire logic wr_en = dest_latch_valid && dest_wr;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            share_ptr_q[i] <= alsg_pkg::WORD_RESET;
            share_bkp_q[i] <= alsg_pkg::WORD_RESET;
         end
         segment_gate_reg_q        <= alsg_pkg::WORD_RESET;
         page_gate_reg_q           <= alsg_pkg::WORD_RESET;
         scratch_work_reg_q        <= alsg_pkg::WORD_RESET;
         translation_control_reg_q <= alsg_pkg::WORD_RESET;
         tlb_target_reg_q          <= alsg_pkg::WORD_RESET;
         v_reg_q                   <= alsg_pkg::WORD_RESET;
         w_reg_q                   <= alsg_pkg::WORD_RESET;
      end else begin
         if (hw_special_addr == alsg_pkg::ADDR_V_REG) begin
            v_reg_q <= hw_special_data;
         end
         if (hw_special_addr == alsg_pkg::ADDR_W_REG) begin
            w_reg_q <= hw_special_data;
         end
         if (wr_en) begin
            unique case (dest_latch_addr)
               alsg_pkg::ADDR_SHARE_PTR_1:  share_ptr_q[0] <= dest_data;
               alsg_pkg::ADDR_SHARE_PTR_2:  share_ptr_q[1] <= dest_data;
               alsg_pkg::ADDR_SHARE_PTR_3:  share_ptr_q[2] <= dest_data;
               alsg_pkg::ADDR_SHARE_PTR_4:  share_ptr_q[3] <= dest_data;
               alsg_pkg::ADDR_SHARE_BKP_1:
                  share_bkp_q[0] <= dest_data & alsg_pkg::BKP_KEEP_MASK;
               alsg_pkg::ADDR_SHARE_BKP_2:
                  share_bkp_q[1] <= dest_data & alsg_pkg::BKP_KEEP_MASK;
               alsg_pkg::ADDR_SHARE_BKP_3:
                  share_bkp_q[2] <= dest_data & alsg_pkg::BKP_KEEP_MASK;
               alsg_pkg::ADDR_SHARE_BKP_4:
                  share_bkp_q[3] <= dest_data & alsg_pkg::BKP_KEEP_MASK;
               alsg_pkg::ADDR_SEGMENT_GATE: segment_gate_reg_q        <= dest_data;
               alsg_pkg::ADDR_PAGE_GATE:    page_gate_reg_q           <= dest_data;
               alsg_pkg::ADDR_SCRATCH_WORK: scratch_work_reg_q        <= dest_data;
               alsg_pkg::ADDR_TRANS_CTRL:   translation_control_reg_q <= dest_data;
               alsg_pkg::ADDR_TLB_TARGET:   tlb_target_reg_q          <= dest_data;
               alsg_pkg::ADDR_V_REG:        v_reg_q                   <= dest_data;
               alsg_pkg::ADDR_W_REG:        w_reg_q                   <= dest_data;
               default: ;
            endcase
         end
      end
   end
endmodule : alsg_gating

// ---- bench/alsg_seq_model.sv ----
/*
 control-word sequencer model: presents one word per put call, releases it
 on idle. assumes the bench calls both tasks from one process.
*/
`timescale 1ns/10ps
module alsg_seq_model (
   // clock
   input  wire logic           core_clk,
   // control word toward the gating block
   output logic                cw_valid,
   output alsg_pkg::alsg_cword_t cw_fields,
   output logic [3:0]          p_low,
   output logic [6:0]          a_src_addr,
   output logic                a_src_is_aux,
   output logic [6:0]          b_src_addr,
   output logic                b_src_is_aux
);
   // quiet word at time zero
   initial begin
      cw_valid = 1'b0;
      cw_fields = '0;
      {p_low, a_src_addr, a_src_is_aux, b_src_addr, b_src_is_aux} = '0;
   end
   // two aux sources are only sent where the b operand stays off the alu
   task automatic put(input logic [4:0] c0, input logic [3:0] c1, input logic [3:0] c2,
                      input logic ad, input logic [6:0] a, input logic aa,
                      input logic [6:0] b, input logic ba, input logic [3:0] pl);
      @(posedge core_clk);
      cw_valid <= 1'b1;
      cw_fields <= '{c0, c1, c2, ad};
      {p_low, a_src_addr, a_src_is_aux, b_src_addr, b_src_is_aux} <= {pl, a, aa, b, ba};
   endtask : put
   // released fields flip so stale values never look valid
   task automatic idle;
      @(posedge core_clk);
      cw_valid <= 1'b0;
      cw_fields <= ~cw_fields;
      {a_src_addr, b_src_addr} <= ~{a_src_addr, b_src_addr};
   endtask : idle
endmodule : alsg_seq_model

// ---- bench/alsg_gating_assertions.sv ----
/*
 port checker for alsg_gating: gate, block, latch and bus relations.
 assumes a single clock domain; bound to every alsg_gating instance.
*/
`timescale 1ns/10ps
module alsg_checker (
   // clock, reset and word inputs
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              cw_valid,
   input wire alsg_pkg::alsg_cword_t cw_fields,
   input wire logic              a_src_is_aux,
   input wire logic              b_src_is_aux,
   input wire logic              dest_wr,
   // design outputs
   input wire logic              a_side_aux_gate,
   input wire logic              b_side_aux_gate,
   input wire logic              a_sense_block,
   input wire logic              b_sense_block,
   input wire logic              ls_bit_gate_block,
   input wire logic              dest_latch_valid,
   input wire logic [6:0]        dest_latch_addr,
   input wire logic [31:0]       a_asm_data,
   input wire logic [31:0]       b_asm_data,
   input wire logic [31:0]       b_ls_bus
);
   // every relation runs on the one control-word clock
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_a_sense_block: assert property (a_sense_block == a_side_aux_gate)
      else $error("a sense latches not blocked with a aux gate");
   a_b_sense_block: assert property (b_sense_block == b_side_aux_gate)
      else $error("b sense latches not blocked with b aux gate");
   a_b_bus_idle: assert property (!b_side_aux_gate |-> b_ls_bus == 32'h0000_0000)
      else $error("b bus driven without b aux gate");
   a_b_bus_gate: assert property (b_side_aux_gate |-> b_ls_bus == b_asm_data)
      else $error("b bus differs from b assembler");
   a_asm_both: assert property ((a_side_aux_gate || b_side_aux_gate) |-> a_asm_data == b_asm_data)
      else $error("assemblers show different registers");
   a_gate_cause: assert property ($rose(a_side_aux_gate) |-> $past(cw_valid, 2))
      else $error("a aux gate without a word two cycles back");
   a_v_dest_latch: assert property (cw_valid && a_src_is_aux && cw_fields.a_dest
      && cw_fields.c0 == alsg_pkg::C0_ARITH && cw_fields.c1 == alsg_pkg::C1_V_A_SOURCE
      |=> dest_latch_valid && dest_latch_addr == alsg_pkg::ADDR_V_REG)
      else $error("v destination not latched");
   a_w_b_select: assert property (cw_valid && b_src_is_aux
      && cw_fields.c0 == alsg_pkg::C0_WORD_MOVE && cw_fields.c2 == alsg_pkg::C2_W_B_SOURCE
      |-> ##2 b_side_aux_gate) else $error("word move did not gate w to b");
   a_bit_gate_wr: assert property (dest_wr && dest_latch_valid |=> ls_bit_gate_block)
      else $error("bit gates open during aux write");
   a_bit_gate_why: assert property (ls_bit_gate_block |-> $past(dest_wr))
      else $error("bit gates blocked without a write");
endmodule : alsg_checker
bind alsg_gating alsg_checker alsg_checker_inst (
   .core_clk(core_clk), .rst(rst), .cw_valid(cw_valid), .cw_fields(cw_fields),
   .a_src_is_aux(a_src_is_aux), .b_src_is_aux(b_src_is_aux), .dest_wr(dest_wr),
   .a_side_aux_gate(a_side_aux_gate), .b_side_aux_gate(b_side_aux_gate),
   .a_sense_block(a_sense_block), .b_sense_block(b_sense_block),
   .ls_bit_gate_block(ls_bit_gate_block), .dest_latch_valid(dest_latch_valid),
   .dest_latch_addr(dest_latch_addr), .a_asm_data(a_asm_data), .b_asm_data(b_asm_data),
   .b_ls_bus(b_ls_bus));

// ---- bench/test_alsg_gating.sv ----
/*
 testbench for alsg_gating: writes, console reads and source words.
 assumes the sequencer model drives the word inputs, the bench the rest.
*/
`timescale 1ns/10ps
module test_alsg_gating;
   logic        core_clk, rst, cw_valid, a_src_is_aux, b_src_is_aux, dest_wr;
   logic        a_side_aux_gate, b_side_aux_gate, a_sense_block, b_sense_block;
   logic        ls_bit_gate_block, dest_latch_valid;
   logic [3:0]  p_low;
   logic [6:0]  a_src_addr, b_src_addr, hw_special_addr, console_addr, dest_latch_addr;
   logic [31:0] dest_data, hw_special_data, a_asm_data, b_asm_data, b_ls_bus, console_data;
   alsg_pkg::alsg_cword_t     cw_fields;
   alsg_pkg::alsg_fetch_sts_t fetch_sts;
   int          error_cnt, n_checks, cyc;
   localparam logic [6:0] ADR [10] = '{7'h60, 7'h61, 7'h64, 7'h65, 7'h68, 7'h69,
                                       7'h6c, 7'h6d, 7'h78, 7'h79};
   alsg_gating alsg_gating_inst (.core_clk(core_clk), .rst(rst), .cw_valid(cw_valid),
      .cw_fields(cw_fields), .p_low(p_low), .a_src_addr(a_src_addr),
      .a_src_is_aux(a_src_is_aux), .b_src_addr(b_src_addr), .b_src_is_aux(b_src_is_aux),
      .dest_wr(dest_wr), .dest_data(dest_data), .hw_special_addr(hw_special_addr),
      .hw_special_data(hw_special_data), .fetch_sts(fetch_sts), .console_addr(console_addr),
      .a_side_aux_gate(a_side_aux_gate), .b_side_aux_gate(b_side_aux_gate),
      .a_sense_block(a_sense_block), .b_sense_block(b_sense_block),
      .ls_bit_gate_block(ls_bit_gate_block), .dest_latch_valid(dest_latch_valid),
      .dest_latch_addr(dest_latch_addr), .a_asm_data(a_asm_data), .b_asm_data(b_asm_data),
      .b_ls_bus(b_ls_bus), .console_data(console_data));
   alsg_seq_model alsg_seq_model_inst (.core_clk(core_clk), .cw_valid(cw_valid),
      .cw_fields(cw_fields), .p_low(p_low), .a_src_addr(a_src_addr),
      .a_src_is_aux(a_src_is_aux), .b_src_addr(b_src_addr), .b_src_is_aux(b_src_is_aux));
   // 25 ns clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // expected stored view: backups keep two bytes, gate and scratch bytes forced
   function automatic logic [31:0] expv(input logic [6:0] a, input logic [31:0] w);
      if (a[6:4] == 3'h6 && a[0]) return w & 32'h00ff_ff00;
      if (a == 7'h78 || a == 7'h79) return {16'hff00, w[15:0]};
      if (a == 7'h7a) return {8'hff, w[23:0]};
      return w;
   endfunction : expv
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask : chk32
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
      end
   endtask : chk1
   task automatic close_out;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   // aux destination word; the write strobe rises with the destination latch so
   // both are sampled high together at the next edge
   task automatic wr_reg(input logic [4:0] c0, input logic [3:0] c1, input logic [6:0] ad,
                         input logic [31:0] dt);
      alsg_seq_model_inst.put(c0, c1, 4'h0, 1'b1, ad, 1'b1, 7'h00, 1'b0, 4'h2);
      alsg_seq_model_inst.idle();
      dest_wr <= 1'b1;
      dest_data <= dt;
      #1 chk1(dest_latch_valid, 1'b1);
      chk32({25'h000_0000, dest_latch_addr}, {25'h000_0000, ad});
      @(posedge core_clk);
      dest_wr <= 1'b0;
      #1 chk1(ls_bit_gate_block, 1'b1);
      chk1(a_side_aux_gate, 1'b1);
   endtask : wr_reg
   // source-only word; outputs stand one cycle, so look just after the edge
   // that follows capture, before the idle word replaces them
   task automatic src(input logic [4:0] c0, input logic [3:0] c2, input logic [6:0] a,
                      input logic aa, input logic [6:0] b, input logic [3:0] pl);
      alsg_seq_model_inst.put(c0, 4'h0, c2, 1'b0, a, aa, b, 1'b1, pl);
      alsg_seq_model_inst.idle();
      @(posedge core_clk);
      #1;
   endtask : src
   task automatic rd_con(input logic [6:0] ad, input logic [31:0] exp);
      @(posedge core_clk);
      console_addr <= ad;
      @(posedge core_clk);
      #1 chk32(console_data, exp);
   endtask : rd_con
   // hang guard, far above the roughly 110 cycles the sequence needs
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         close_out();
      end
   end
   // main sequence
   initial begin
      {rst, dest_wr, dest_data, hw_special_addr, hw_special_data} = {1'b1, 72'h0};
      {fetch_sts, console_addr, error_cnt, n_checks, cyc} = '0;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) rd_con(ADR[i], expv(ADR[i], 32'h0000_0000));
      for (int i = 0; i < 10; i++) begin
         wr_reg(5'h00, 4'h0, ADR[i], 32'h1234_5678);
         rd_con(ADR[i], expv(ADR[i], 32'h1234_5678));
      end
      wr_reg(5'h00, 4'h0, 7'h7a, 32'h0bad_cafe);
      rd_con(7'h7a, 32'hffad_cafe);
      src(5'h00, 4'h0, 7'h60, 1'b1, 7'h7a, 4'h2);
      chk32(b_asm_data, 32'h1234_5678);
      chk32(a_asm_data, 32'h1234_5678);
      wr_reg(alsg_pkg::C0_ARITH, alsg_pkg::C1_V_A_SOURCE, 7'h51, 32'h0051_0a0a);
      rd_con(7'h51, 32'h0051_0a0a);
      @(posedge core_clk) {hw_special_addr, hw_special_data} <= {7'h52, 32'h0052_5a5a};
      @(posedge core_clk) hw_special_addr <= 7'h00;
      for (int p = 2; p < 8; p += 3) begin
         src(alsg_pkg::C0_WORD_MOVE, alsg_pkg::C2_W_B_SOURCE, 7'h00, 1'b0, 7'h52, p[3:0]);
         chk1(b_side_aux_gate, 1'b1);
         chk1(b_sense_block, 1'b1);
         chk32(b_ls_bus, 32'h0052_5a5a);
      end
      @(posedge core_clk) fetch_sts <= '{4'ha, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h5c};
      rd_con(7'h56, 32'h0000_5cab);
      @(posedge core_clk) fetch_sts <= '{4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00};
      rd_con(7'h56, 32'h0000_0002);
      src(5'h00, 4'h0, 7'h56, 1'b1, 7'h00, 4'h2);
      chk1(a_side_aux_gate, 1'b0);
      rd_con(7'h70, 32'h0000_0000);
      @(posedge core_clk) rst <= 1'b1;
      @(posedge core_clk) rst <= 1'b0;
      rd_con(7'h60, 32'h0000_0000);
      close_out();
   end
endmodule : test_alsg_gating
